// File: core/spi_mram_cmd_protect.v
`timescale 1ns/100ps
`default_nettype none
`include "spi_mram_consts.vh"

module spi_mram_cmd_protect (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire cs_n_i,
    input  wire sck_i,
    input  wire si_i,
    input  wire wp_n_i,
    output wire so_o,
    output wire so_oe_n_o,
    output wire sleep_o
);

    // wake recovery in clk_i cycles, cut to the counter width on purpose
    localparam integer      REC_CYC  = `WAKE_REC_CYC;
    localparam [`REC_W-1:0] REC_LOAD = REC_CYC[`REC_W-1:0];

    // pin synchronisers, third stage only for edge finding
    reg                 cs_s1;
    reg                 cs_s2;
    reg                 cs_s3;
    reg                 sck_s1;
    reg                 sck_s2;
    reg                 sck_s3;
    reg                 si_s1;
    reg                 si_s2;
    reg                 wp_s1;
    reg                 wp_s2;

    // where the frame stands: state, bit and byte position
    reg  [2:0]          state;
    reg  [2:0]          bit_cnt;
    reg  [1:0]          byte_cnt;

    // shift registers for incoming bits and the address bytes
    reg  [6:0]          rx_sr;
    reg  [15:0]         addr_sr;
    reg  [`ADDR_W-1:0]  addr;

    // serial output side; tx_sr also keeps the command code
    // through the address phase to tell a read from a write
    reg  [7:0]          tx_sr;
    reg                 tx_on;
    reg                 so_q;
    reg                 so_oe_n;

    // frame mode, sleep and wake recovery
    reg                 mode3;
    reg                 seen_rise;
    reg                 asleep;
    reg  [`REC_W-1:0]   rec_cnt;

    // status storage: latch is volatile, the rest is not
    reg                 latch;
    reg  [7:0]          nv_status;

    // the array itself
    reg  [7:0]          mem [0:`MEM_DEPTH-1];

    // pin edges seen in the clk_i domain
    wire                cs_fall;
    wire                cs_rise;
    wire                sck_rise;
    wire                sck_fall;

    // received byte and the status byte as read back
    wire [7:0]          rx_byte;
    wire                byte_done;
    wire [7:0]          status_byte;
    wire [1:0]          bp;
    wire                lock;
    wire                wp_high;

    // protection decisions and the array write strobe
    wire                hw_locked;
    wire                status_writable;
    wire [`ADDR_W-1:0]  start_addr;
    wire                mem_we;

    // factory state of the non-volatile bits; reset must not touch them
    integer i;
    initial begin
        nv_status = `SR_RESET;
        for (i = 0; i < `MEM_DEPTH; i = i + 1) begin
            mem[i] = 8'h00;
        end
    end

    // bring every pin into the clk_i domain; only the second stage
    // reads the first, the third exists only to find edges
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            cs_s3  <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            si_s1  <= 1'b0;
            si_s2  <= 1'b0;
            wp_s1  <= 1'b0;
            wp_s2  <= 1'b0;
        end else begin
            cs_s1  <= cs_n_i;
            cs_s2  <= cs_s1;
            cs_s3  <= cs_s2;
            sck_s1 <= sck_i;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            si_s1  <= si_i;
            si_s2  <= si_s1;
            wp_s1  <= wp_n_i;
            wp_s2  <= wp_s1;
        end
    end

    // edges; clock edges only count while selected, and the link
    // clock needs more than one clk_i cycle per level or an edge is lost
    assign cs_fall  = cs_s3 & ~cs_s2;
    assign cs_rise  = ~cs_s3 & cs_s2;
    assign sck_rise = ~sck_s3 & sck_s2 & ~cs_s2 & ~cs_fall;
    assign sck_fall = sck_s3 & ~sck_s2 & ~cs_s2 & ~cs_fall;

    // incoming byte, msb first; si and sck share the same latency
    assign rx_byte   = {rx_sr, si_s2};
    assign byte_done = sck_rise & (bit_cnt == `BIT_LAST);

    // status byte as read back; the latch is the only volatile bit
    assign status_byte = {nv_status[`SR_LOCK:`SR_BP_LO], latch,
                          nv_status[`SR_FREE0]};
    assign bp          = {nv_status[`SR_BP_HI], nv_status[`SR_BP_LO]};
    assign lock        = nv_status[`SR_LOCK];
    assign wp_high     = wp_s2;

    // hardware protection: lock set and pin low freezes all status
    // bits but the latch, block bits included, until the pin goes high
    assign hw_locked = lock & ~wp_high;

    // writable only with the latch set and no hardware lock; with the
    // lock clear the pin level does not matter, with the pin high the
    // block bits alone decide what the array protects
    assign status_writable = latch & ~hw_locked;

    // address from the two stored bytes and the one arriving
    assign start_addr = {addr_sr[`ADDR_W-9:0], rx_byte};

    // block protection by address
    function prot;
        input [1:0]         code;
        input [`ADDR_W-1:0] a;
        begin
            case (code)
                `BP_NONE:    prot = 1'b0;
                `BP_QUARTER: prot = (a[`ADDR_W-1:`ADDR_W-2] ==
                                     `TOP_QUARTER);
                `BP_HALF:    prot = a[`ADDR_W-1];
                default:     prot = 1'b1;
            endcase
        end
    endfunction

    // a refused byte is simply not stored; addressing goes on
    assign mem_we = byte_done & (state == `ST_WDATA) & latch
                    & ~prot(bp, addr);

    // array write port, one byte per eight link clocks, no busy time;
    // the array has no reset, its contents are kept like the status
    always @(posedge clk_i) begin
        if (mem_we) begin
            mem[addr] <= rx_byte;
        end
    end

    // status write; the latch bit of the data byte is ignored, so a
    // status write can never set the latch behind the host's back
    always @(posedge clk_i) begin
        if (byte_done && state == `ST_SWR && status_writable) begin
            nv_status <= {rx_byte[`SR_LOCK:`SR_BP_LO], 1'b0,
                          rx_byte[`SR_FREE0]};
        end
    end

    // command engine; a command acts on the eighth rising edge of its
    // byte, not when select rises, and a partial byte is dropped
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            state     <= `ST_IGNORE;
            bit_cnt   <= 3'h0;
            byte_cnt  <= 2'h0;
            rx_sr     <= 7'h00;
            addr_sr   <= 16'h0000;
            addr      <= {`ADDR_W{1'b0}};
            tx_sr     <= 8'd0;
            tx_on     <= 1'b0;
            so_q      <= 1'b0;
            so_oe_n   <= 1'b1;
            mode3     <= 1'b0;
            seen_rise <= 1'b0;
            latch     <= 1'b0;
            asleep    <= 1'b0;
            rec_cnt   <= {`REC_W{1'b0}};
        end else begin
            // wake recovery runs down on its own
            if (rec_cnt != {`REC_W{1'b0}}) begin
                rec_cnt <= rec_cnt - 1'b1;
            end
            // select falling opens a frame; the link clock level now
            // picks the mode, and a frame inside wake recovery is shut out
            if (cs_fall) begin
                bit_cnt   <= 3'h0;
                byte_cnt  <= 2'h0;
                tx_on     <= 1'b0;
                seen_rise <= 1'b0;
                mode3     <= sck_s2;
                // a frame inside recovery is not served
                if (rec_cnt != {`REC_W{1'b0}}) begin
                    state <= `ST_IGNORE;
                end else begin
                    state <= `ST_CMD;
                end
            end else if (cs_rise) begin
                // release the output as soon as the frame ends
                state   <= `ST_IGNORE;
                tx_on   <= 1'b0;
                so_oe_n <= 1'b1;
            end else if (sck_rise) begin
                // serial input is taken on every rising link edge
                seen_rise <= 1'b1;
                bit_cnt   <= bit_cnt + 1'b1;
                rx_sr     <= rx_byte[6:0];
                if (bit_cnt == `BIT_LAST) begin
                    case (state)
                        `ST_CMD: begin
                            if (asleep) begin
                                // only wake leaves sleep
                                if (rx_byte == `CMD_WAKE) begin
                                    asleep  <= 1'b0;
                                    rec_cnt <= REC_LOAD;
                                end
                                state <= `ST_IGNORE;
                            end else begin
                                case (rx_byte)
                                    `CMD_LATCH_SET: begin
                                        latch <= 1'b1;
                                        state <= `ST_IGNORE;
                                    end
                                    `CMD_LATCH_CLEAR: begin
                                        latch <= 1'b0;
                                        state <= `ST_IGNORE;
                                    end
                                    `CMD_STATUS_READ: begin
                                        tx_sr <= status_byte;
                                        tx_on <= 1'b1;
                                        state <= `ST_SRD;
                                    end
                                    `CMD_STATUS_WRITE: begin
                                        state <= `ST_SWR;
                                    end
                                    `CMD_DATA_READ: begin
                                        byte_cnt <= 2'h0;
                                        tx_on    <= 1'b0;
                                        state    <= `ST_ADDR;
                                        addr_sr  <= 16'h0000;
                                        so_q     <= 1'b0;
                                        // remember the direction
                                        tx_sr    <= `CMD_DATA_READ;
                                    end
                                    `CMD_DATA_WRITE: begin
                                        byte_cnt <= 2'h0;
                                        state    <= `ST_ADDR;
                                        addr_sr  <= 16'h0000;
                                        // remember the direction
                                        tx_sr    <= `CMD_DATA_WRITE;
                                    end
                                    `CMD_SLEEP: begin
                                        asleep <= 1'b1;
                                        state  <= `ST_IGNORE;
                                    end
                                    default: begin
                                        state <= `ST_IGNORE;
                                    end
                                endcase
                            end
                        end
                        `ST_ADDR: begin
                            addr_sr  <= {addr_sr[7:0], rx_byte};
                            byte_cnt <= byte_cnt + 1'b1;
                            if (byte_cnt == `ADDR_LAST_BYTE) begin
                                // tx_sr still holds the command code
                                if (tx_sr == `CMD_DATA_READ) begin
                                    tx_sr <= mem[start_addr];
                                    addr  <= start_addr + 1'b1;
                                    tx_on <= 1'b1;
                                    state <= `ST_RDATA;
                                end else begin
                                    addr  <= start_addr;
                                    state <= `ST_WDATA;
                                end
                            end
                        end
                        `ST_RDATA: begin
                            // next byte; the counter wraps to zero
                            tx_sr <= mem[addr];
                            addr  <= addr + 1'b1;
                        end
                        `ST_WDATA: begin
                            // refused or stored, the address moves on
                            addr <= addr + 1'b1;
                        end
                        `ST_SRD: begin
                            // status repeats, fresh each byte, while clocked
                            tx_sr <= status_byte;
                        end
                        `ST_SWR: begin
                            // one data byte only; the rest is dropped
                            state <= `ST_IGNORE;
                        end
                        default: begin
                            state <= `ST_IGNORE;
                        end
                    endcase
                end
            end else if (sck_fall && (seen_rise || !mode3)) begin
                // mode 3 opens with a fall that carries no data
                if (tx_on) begin
                    so_q    <= tx_sr[7];
                    tx_sr   <= {tx_sr[6:0], 1'b0};
                    so_oe_n <= 1'b0;
                end
            end
        end
    end

    // serial output straight from flip-flops
    assign so_o      = so_q;
    assign so_oe_n_o = so_oe_n;
    assign sleep_o   = asleep;

endmodule // spi_mram_cmd_protect
`default_nettype wire

// File: core/spi_mram_consts.vh
`ifndef SPI_MRAM_CONSTS_VH
`define SPI_MRAM_CONSTS_VH

// command codes
`define CMD_LATCH_SET    8'h06
`define CMD_LATCH_CLEAR  8'h04
`define CMD_STATUS_READ  8'h05
`define CMD_STATUS_WRITE 8'h01
`define CMD_DATA_READ    8'h03
`define CMD_DATA_WRITE   8'h02
`define CMD_SLEEP        8'hb9
`define CMD_WAKE         8'hab

// status byte layout
`define SR_LOCK    7
`define SR_BP_HI   3
`define SR_BP_LO   2
`define SR_LATCH   1
`define SR_FREE0   0
`define SR_RESET   8'h00

// block protect codes
`define BP_NONE    2'h0
`define BP_QUARTER 2'h1
`define BP_HALF    2'h2
`define TOP_QUARTER 2'h3

// array geometry
`define ADDR_W     19
`define MEM_DEPTH  524288
`define ADDR_LAST_BYTE 2'h2
`define BIT_LAST   3'h7

// engine states
`define ST_CMD     3'h0
`define ST_ADDR    3'h1
`define ST_RDATA   3'h2
`define ST_WDATA   3'h3
`define ST_SRD     3'h4
`define ST_SWR     3'h5
`define ST_IGNORE  3'h6

// timing
`define CLK_MHZ          100
`define WAKE_RECOVERY_NS 1000
`define WAKE_REC_CYC ((`WAKE_RECOVERY_NS*`CLK_MHZ+999)/1000)
`define REC_W            8

`endif

// File: test/spi_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
    input  wire logic clk_i,
    input  wire logic so_i,
    output var logic  cs_n_o,
    output var logic  sck_o,
    output var logic  si_o
);
    int half_cyc = 8; // raise for a slow host
    initial begin
        cs_n_o = 1'b1;
        sck_o  = 1'b0;
        si_o   = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one frame of n whole bytes taken from the top of tx
    task automatic xfer(input logic [63:0] tx, input int n, input bit m3,
                        output logic [63:0] rx);
        rx = '0;
        sck_o = m3; // idle level picks the mode
        tick(half_cyc);
        cs_n_o = 1'b0;
        tick(half_cyc);
        for (int i = 0; i < 8 * n; i++) begin
            sck_o = 1'b0;
            si_o  = tx[63 - i];
            tick(half_cyc);
            sck_o = 1'b1;
            rx    = {rx[62:0], so_i};
            tick(half_cyc);
        end
        if (!m3) begin
            sck_o = 1'b0;
            tick(half_cyc);
        end
        cs_n_o = 1'b1;
        si_o   = ~si_o; // released line shows no stale value
        rx     = rx << (64 - 8 * n);
        tick(half_cyc);
    endtask
endmodule // spi_host_model
`default_nettype wire

// File: test/spi_mram_props.sv
`timescale 1ns/100ps
`default_nettype none
module spi_mram_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    input wire logic sleep_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // select high long enough to pass the two-flop sync
    sequence s_cs_idle; cs_n_i [*5]; endsequence
    // a whole command byte takes far longer than 100 clk
    sequence s_cs_long; $past(cs_n_i, 100) == 1'b0 && !cs_n_i; endsequence
    property p_oe_idle; s_cs_idle |-> so_oe_n_o; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
    property p_oe_hold; !so_oe_n_o && !cs_n_i |=> !so_oe_n_o; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("oe held");
    property p_oe_awake; $fell(so_oe_n_o) |-> !sleep_o; endproperty
    a_oe_awake: assert property (p_oe_awake) else $error("oe sleep");
    property p_oe_late; $fell(so_oe_n_o) |-> s_cs_long; endproperty
    a_oe_late: assert property (p_oe_late) else $error("oe early");
    property p_oe_edge; $fell(so_oe_n_o) |-> !$past(sck_i, 2); endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("oe edge");
    // output moves only after a falling clock edge
    property p_so_hold; (sck_i && !so_oe_n_o) [*6] |-> $stable(so_o);
    endproperty
    a_so_hold: assert property (p_so_hold) else $error("so moved");
    property p_slp_idle; s_cs_idle |-> $stable(sleep_o); endproperty
    a_slp_idle: assert property (p_slp_idle) else $error("sleep");
    property p_slp_cmd; $changed(sleep_o) |-> s_cs_long; endproperty
    a_slp_cmd: assert property (p_slp_cmd) else $error("sleep cmd");
endmodule // spi_mram_props
bind spi_mram_cmd_protect spi_mram_props spi_mram_props_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
    .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
    .sleep_o(sleep_o));
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk_i;
    logic        rst_n_i;
    logic        wp_n_i;
    wire logic   cs_n;
    wire logic   sck;
    wire logic   si;
    wire logic   so_o;
    wire logic   so_oe_n_o;
    wire logic   sleep_o;
    wire logic   so_line;
    logic [63:0] rx;
    logic [7:0]  st;
    logic [15:0] d;
    logic [7:0]  e0, e5, e7;
    int          bad_count, checks_done;
    // released output floats to its pull-up
    assign so_line = so_oe_n_o ? 1'b1 : so_o;
    spi_mram_cmd_protect spi_mram_cmd_protect_inst (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
        .wp_n_i(wp_n_i), .so_o(so_o), .so_oe_n_o(so_oe_n_o),
        .sleep_o(sleep_o));
    spi_host_model host (.clk_i(clk_i), .so_i(so_line), .cs_n_o(cs_n),
        .sck_o(sck), .si_o(si));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input string what, input logic [7:0] exp, got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic x(input logic [63:0] tx, input int n, input bit m3);
        host.xfer(tx, n, m3, rx);
    endtask
    task automatic cmd(input logic [7:0] c);
        x({c, 56'h0}, 1, 1'b0);
    endtask
    task automatic sw(input logic [7:0] v);
        x({8'h01, v, 48'h0}, 2, 1'b0);
    endtask
    // second of two status reads is trusted
    task automatic rds(input bit m3);
        x({8'h05, 56'h0}, 2, m3);
        x({8'h05, 56'h0}, 2, m3);
        st = rx[55:48];
    endtask
    task automatic wr(input logic [23:0] a, input logic [15:0] v, int n);
        x({8'h02, a, v, 16'h0}, 4 + n, 1'b0);
    endtask
    task automatic rd(input logic [23:0] a, input int n);
        x({8'h03, a, 32'h0}, 4 + n, 1'b0);
        d = rx[31:16];
    endtask
    task automatic pwr_up;
        rst_n_i = 1'b0;
        host.tick(8);
        rst_n_i = 1'b1;
        host.tick(8);
    endtask
    task automatic t_latch;
        rds(1'b0);
        chk("status", 8'h00, st);
        cmd(8'h06);
        rds(1'b1);
        chk("latch set", 8'h02, st);
        cmd(8'h04);
        rds(1'b0);
        chk("latch clear", 8'h00, st);
        wr(24'h000000, 16'ha500, 1);
        rd(24'h000000, 1);
        chk("locked write", 8'h00, d[15:8]);
        sw(8'h0c);
        rds(1'b0);
        chk("locked status", 8'h00, st);
    endtask
    task automatic t_stream;
        cmd(8'h06);
        wr(24'hf7ffff, 16'h1122, 2);
        wr(24'h000001, 16'h3344, 2);
        host.half_cyc = 12;
        rd(24'h07ffff, 2);
        host.half_cyc = 8;
        chk("top byte", 8'h11, d[15:8]);
        chk("wrapped", 8'h22, d[7:0]);
        rd(24'h800001, 2);
        chk("stream", 8'h33, d[15:8]);
        chk("stream next", 8'h44, d[7:0]);
    endtask
    task automatic t_protect;
        {e7, e0, e5} = 24'h112200;
        for (int bp = 0; bp < 4; bp++) begin
            sw({4'h0, bp[1:0], 2'b00});
            rds(1'b0);
            chk("block code", {4'h0, bp[1:0], 2'b10}, st);
            wr(24'h07ffff, {6'h10, bp[1:0], 6'h14, bp[1:0]}, 2);
            wr(24'h05ffff, {6'h18, bp[1:0], 8'h00}, 1);
            if (bp == 0) e7 = {6'h10, bp[1:0]};
            if (bp < 3) e0 = {6'h14, bp[1:0]};
            if (bp < 2) e5 = {6'h18, bp[1:0]};
            rd(24'h07ffff, 2);
            chk("quarter", e7, d[15:8]);
            chk("advance", e0, d[7:0]);
            rd(24'h05ffff, 1);
            chk("half", e5, d[15:8]);
        end
    endtask
    task automatic t_lock;
        wp_n_i = 1'b0;
        sw(8'h84);
        rds(1'b0);
        chk("pin ignored", 8'h86, st);
        sw(8'h00);
        rds(1'b0);
        chk("hw lock", 8'h86, st);
        wp_n_i = 1'b1;
        sw(8'h71);
        rds(1'b0);
        chk("sw mode", 8'h73, st);
    endtask
    task automatic t_sleep;
        cmd(8'hb9);
        chk("asleep", 8'h01, {7'h0, sleep_o});
        cmd(8'h04);
        x({8'h05, 56'h0}, 2, 1'b0);
        chk("silent", 8'hff, rx[55:48]);
        cmd(8'hab);
        chk("awake", 8'h00, {7'h0, sleep_o});
        host.tick(120);
        rds(1'b0);
        chk("kept", 8'h73, st);
        cmd(8'hb9);
        pwr_up;
        chk("no sleep", 8'h00, {7'h0, sleep_o});
        rds(1'b0);
        chk("kept bits", 8'h71, st);
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        bad_count = 0;
        checks_done = 0;
        wp_n_i = 1'b1;
        pwr_up;
        t_latch;
        t_stream;
        t_protect;
        t_lock;
        t_sleep;
        finish_test;
    end
    // run needs about 28k clk
    initial begin
        repeat (95000) @(posedge clk_i);
        bad_count++;
        finish_test;
    end
endmodule // tb_top
`default_nettype wire
